// ---- rtl/aiq_pkg.sv ----
package aiq_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int SCAN_DEPTH = 8;
    localparam int SCAN_IDX_W = 3;

    localparam logic [ADDR_W-1:0] REG_CTRL     = 6'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 6'h01;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h02;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h03;
    localparam logic [ADDR_W-1:0] REG_COUNT    = 6'h04;
    localparam logic [ADDR_W-1:0] REG_DIVIDER  = 6'h05;
    localparam logic [ADDR_W-1:0] REG_TRIG     = 6'h06;
    localparam logic [ADDR_W-1:0] REG_SCANLEN  = 6'h07;
    localparam logic [ADDR_W-1:0] REG_SPDATA   = 6'h08;
    localparam logic [ADDR_W-1:0] REG_CMD      = 6'h09;
    localparam logic [ADDR_W-1:0] REG_SCAN0    = 6'h10;

    // control fields
    localparam int CTRL_TIMING_LO = 0; // 2 bits
    localparam int CTRL_FINITE    = 2;
    localparam int CTRL_EXTCLK    = 3;
    localparam int CTRL_REF_EN    = 4;
    localparam int CTRL_PAUSE_EN  = 5;
    // command bits
    localparam int CMD_CONVERT = 0;
    localparam int CMD_ARM     = 1;
    localparam int CMD_STOP    = 2;
    // trigger select fields: one bit per trigger, set selects the analog source
    localparam int TRIG_START_ANA = 0;
    localparam int TRIG_REF_ANA   = 1;
    localparam int TRIG_PAUSE_ANA = 2;
    // irq bits
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_OVERFLOW = 1;
    localparam int IRQ_LATE     = 2;
    localparam int IRQ_W        = 3;
    // scan entry fields: [7:0] channel, [10:8] range, [12:11] ground mode
    localparam int SCAN_CH_LO   = 0;
    localparam int SCAN_RNG_LO  = 8;
    localparam int SCAN_GND_LO  = 11;

    localparam logic [15:0] DIVIDER_RESET = 16'h00FA;
    localparam logic [31:0] COUNT_RESET   = 32'h0000_0001;
    localparam logic [3:0]  SCANLEN_RESET = 4'h1;

    typedef enum logic [1:0] {
        TM_ON_DEMAND,
        TM_BUFFERED,
        TM_SINGLE_POINT,
        TM_RSVD
    } aiq_timing_t;

    typedef enum logic [1:0] {
        GND_TWO_WIRE,
        GND_GROUNDED_SE,
        GND_SENSED_SE,
        GND_RSVD
    } aiq_gnd_t;
endpackage

// ---- rtl/aiq_pacer.sv ----
`timescale 1ns/100ps
module aiq_pacer #(
    parameter int DIV_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire logic             running,
    input  wire logic             useExternal,
    input  wire logic             extPulse,
    input  wire logic             paused,
    input  wire logic [DIV_W-1:0] divider,
    output logic                  tick
);
    import aiq_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             extPrev_reg;
    wire              intTick  = running && (cnt_reg == '0);
    wire              extTick  = running && extPulse && !extPrev_reg;
    wire              rawTick  = useExternal ? extTick : intTick;

    assign cnt_next = (!running || cnt_reg == '0) ? divider : cnt_reg - 1'b1;
    assign tick = rawTick && !paused;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg     <= '0;
            extPrev_reg <= 1'b0;
        end else if (clkEn) begin
            cnt_reg     <= cnt_next;
            extPrev_reg <= extPulse;
        end
    end

    chk_pause_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
        paused |-> !tick) else $error("tick during pause");
    chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !running |-> !tick) else $error("tick while idle");
endmodule

// ---- rtl/aiq_sequencer.sv ----
`timescale 1ns/100ps
module aiq_sequencer #(
    parameter int FIFO_DEPTH  = 16,
    parameter int FIFO_AW     = 4,
    parameter int BURST_LEN   = 4,
    parameter bit HAS_ANALOG  = 1'b1
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset_n,
    input  wire logic                       clkEn,
    input  wire logic [aiq_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [31:0]                regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic [31:0]                     regRdata,
    output logic                            irq,
    input  wire logic                       extSampleClk,
    input  wire logic                       digStartTrig,
    input  wire logic                       anaStartTrig,
    input  wire logic                       digRefTrig,
    input  wire logic                       anaRefTrig,
    input  wire logic                       digPauseTrig,
    input  wire logic                       anaPauseTrig,
    output logic                            convStart,
    output logic [7:0]                      convChannel,
    output logic [2:0]                      pgaRange,
    output logic [1:0]                      gndMode,
    input  wire logic                       convDone,
    input  wire logic [aiq_pkg::DATA_W-1:0] convData,
    output logic                            dmaValid,
    output logic [aiq_pkg::DATA_W-1:0]      dmaData,
    output logic                            dmaLast,
    input  wire logic                       dmaReady,
    output logic                            refSeen,
    output logic                            running
);
    import aiq_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } aiq_state_t;

    aiq_state_t state_reg;
    aiq_state_t state_next;

    logic [5:0]        ctrl_reg;
    logic [2:0]        trig_reg;
    logic [31:0]       count_reg;
    logic [15:0]       div_reg;
    logic [3:0]        scanLen_reg;
    logic [12:0]       scan_reg [SCAN_DEPTH];
    logic [IRQ_W-1:0]  irqStat_reg;
    logic [IRQ_W-1:0]  irqMask_reg;
    logic [31:0]       done_reg;
    logic [SCAN_IDX_W-1:0] idx_reg;
    logic              busy_reg;
    logic              spFull_reg;
    logic [DATA_W-1:0] spData_reg;
    logic [DATA_W-1:0] fifo_reg [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wrPtr_reg;
    logic [FIFO_AW-1:0] rdPtr_reg;
    logic [FIFO_AW:0]   level_reg;
    logic [7:0]        burst_reg;
    logic [31:0]       rdata_next;

    function automatic logic pick(input logic useAna, input logic dig, input logic ana);
        pick = (useAna && HAS_ANALOG) ? ana : dig;
    endfunction

    aiq_timing_t timing;
    assign timing = aiq_timing_t'(ctrl_reg[CTRL_TIMING_LO +: 2]);
    wire finiteMode = ctrl_reg[CTRL_FINITE];
    wire wrHit      = regWrite && clkEn;
    wire cmdWr      = wrHit && regAddr == REG_CMD;
    wire armCmd     = cmdWr && regWdata[CMD_ARM];
    wire stopCmd    = cmdWr && regWdata[CMD_STOP];
    wire swConvert  = cmdWr && regWdata[CMD_CONVERT] && timing == TM_ON_DEMAND;
    wire startTrig  = pick(trig_reg[TRIG_START_ANA], digStartTrig, anaStartTrig);
    wire refTrig    = pick(trig_reg[TRIG_REF_ANA], digRefTrig, anaRefTrig);
    wire pauseTrig  = pick(trig_reg[TRIG_PAUSE_ANA], digPauseTrig, anaPauseTrig) && ctrl_reg[CTRL_PAUSE_EN];
    wire hwPaced    = timing != TM_ON_DEMAND;
    wire tick;
    wire startConv  = running && !busy_reg && (hwPaced ? tick : swConvert);
    wire [12:0] entry = scan_reg[idx_reg];
    wire lastEntry  = ({1'b0, idx_reg} + 4'h1) >= scanLen_reg;
    wire buffered   = timing == TM_BUFFERED || timing == TM_ON_DEMAND;
    wire sample     = convDone && busy_reg;
    wire fifoFull   = level_reg == (FIFO_AW+1)'(FIFO_DEPTH);
    wire push       = sample && buffered;
    wire overwrite  = push && fifoFull;
    wire pop        = dmaValid && dmaReady;
    wire countHit   = finiteMode && sample && (done_reg + 32'h1 >= count_reg);
    wire spRead     = regRead && clkEn && regAddr == REG_SPDATA;
    wire lateEvt    = timing == TM_SINGLE_POINT && tick && running && spFull_reg;
    wire [IRQ_W-1:0] irqSet = {lateEvt, overwrite, countHit};
    wire [IRQ_W-1:0] irqClr = (wrHit && regAddr == REG_IRQ_STAT) ? regWdata[IRQ_W-1:0] : '0;

    assign running  = state_reg == ST_RUN;
    assign irq      = |(irqStat_reg & irqMask_reg);
    assign dmaValid = level_reg != '0 && (burst_reg != 8'h00 || level_reg >= (FIFO_AW+1)'(BURST_LEN)
                      || !running);
    assign dmaData  = fifo_reg[rdPtr_reg];
    assign dmaLast  = dmaValid && (burst_reg == 8'h01 || (burst_reg == 8'h00 && BURST_LEN == 1));

    aiq_pacer #(.DIV_W(16)) pacer (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clkEn       (clkEn),
        .running     (running && hwPaced),
        .useExternal (ctrl_reg[CTRL_EXTCLK]),
        .extPulse    (extSampleClk),
        .paused      (pauseTrig),
        .divider     (div_reg),
        .tick        (tick)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (armCmd) state_next = ST_ARMED;
            ST_ARMED: if (stopCmd) state_next = ST_IDLE;
                      else if (startTrig) state_next = ST_RUN;
            ST_RUN:   if (stopCmd || countHit) state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always_comb begin
        rdata_next = 32'h0;
        case (regAddr)
            REG_CTRL:     rdata_next = {26'h0, ctrl_reg};
            REG_STATUS:   rdata_next = {16'h0, 2'h0, level_reg, refSeen, spFull_reg, busy_reg,
                                        4'(idx_reg), 2'(state_reg)} ;
            REG_IRQ_STAT: rdata_next = {29'h0, irqStat_reg};
            REG_IRQ_MASK: rdata_next = {29'h0, irqMask_reg};
            REG_COUNT:    rdata_next = count_reg;
            REG_DIVIDER:  rdata_next = {16'h0, div_reg};
            REG_TRIG:     rdata_next = {29'h0, trig_reg};
            REG_SCANLEN:  rdata_next = {28'h0, scanLen_reg};
            REG_SPDATA:   rdata_next = {16'h0, spData_reg};
            default: begin
                if (regAddr >= REG_SCAN0 && regAddr < REG_SCAN0 + ADDR_W'(SCAN_DEPTH))
                    rdata_next = {19'h0, scan_reg[SCAN_IDX_W'(regAddr - REG_SCAN0)]};
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < SCAN_DEPTH; g++) begin : gScan
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n)
                    scan_reg[g] <= 13'h0000;
                else if (wrHit && regAddr == REG_SCAN0 + ADDR_W'(g))
                    scan_reg[g] <= regWdata[12:0];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg    <= 6'h00;
            trig_reg    <= 3'h0;
            count_reg   <= COUNT_RESET;
            div_reg     <= DIVIDER_RESET;
            scanLen_reg <= SCANLEN_RESET;
            irqMask_reg <= '0;
            regRdata    <= 32'h0;
        end else if (clkEn) begin
            regRdata <= regRead ? rdata_next : 32'h0;
            if (regWrite) begin
                if (regAddr == REG_CTRL)     ctrl_reg    <= regWdata[5:0];
                if (regAddr == REG_TRIG)     trig_reg    <= regWdata[2:0];
                if (regAddr == REG_COUNT)    count_reg   <= regWdata;
                if (regAddr == REG_DIVIDER)  div_reg     <= regWdata[15:0];
                if (regAddr == REG_SCANLEN)  scanLen_reg <= regWdata[3:0];
                if (regAddr == REG_IRQ_MASK) irqMask_reg <= regWdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= ST_IDLE;
            irqStat_reg <= '0;
            done_reg    <= 32'h0;
            idx_reg     <= '0;
            busy_reg    <= 1'b0;
            convStart   <= 1'b0;
            convChannel <= 8'h00;
            pgaRange    <= 3'h0;
            gndMode     <= 2'h0;
            refSeen     <= 1'b0;
        end else if (clkEn) begin
            state_reg   <= state_next;
            irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet; // set wins
            convStart   <= startConv;
            if (startConv) begin
                convChannel <= entry[SCAN_CH_LO +: 8];
                pgaRange    <= entry[SCAN_RNG_LO +: 3];
                gndMode     <= entry[SCAN_GND_LO +: 2];
                busy_reg    <= 1'b1;
            end else if (sample) begin
                busy_reg <= 1'b0;
                idx_reg  <= lastEntry ? '0 : idx_reg + 1'b1;
                done_reg <= done_reg + 32'h1;
            end
            if (armCmd) begin
                done_reg <= 32'h0;
                idx_reg  <= '0;
                refSeen  <= 1'b0;
            end
            if (running && refTrig && ctrl_reg[CTRL_REF_EN] && finiteMode)
                refSeen <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg  <= '0;
            rdPtr_reg  <= '0;
            level_reg  <= '0;
            burst_reg  <= 8'h00;
            spFull_reg <= 1'b0;
            spData_reg <= '0;
        end else if (clkEn) begin
            if (push) begin
                fifo_reg[wrPtr_reg] <= convData;
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            // a pop or an overwrite retires the oldest sample; both at once retire it only once
            if (pop || overwrite)
                rdPtr_reg <= rdPtr_reg + 1'b1;
            if (push && !fifoFull && !pop)
                level_reg <= level_reg + 1'b1;
            else if (pop && !push)
                level_reg <= level_reg - 1'b1;
            if (pop)
                burst_reg <= (burst_reg == 8'h00) ? 8'(BURST_LEN - 1) : burst_reg - 8'h01;
            if (sample && timing == TM_SINGLE_POINT) begin
                spData_reg <= convData;
                spFull_reg <= 1'b1;
            end else if (spRead)
                spFull_reg <= 1'b0;
        end
    end

    chk_ondemand_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && timing == TM_ON_DEMAND && !swConvert) |=> !convStart) else $error("self conversion");
    chk_finite_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && countHit) |=> state_reg == ST_IDLE) else $error("finite run did not stop");
    chk_overflow_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && overwrite) |=> irqStat_reg[IRQ_OVERFLOW]) else $error("overflow not flagged");
    chk_late_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && lateEvt) |=> irqStat_reg[IRQ_LATE]) else $error("lateness not flagged");
    chk_gain_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && startConv) |=> pgaRange == $past(entry[SCAN_RNG_LO +: 3])) else $error("range not loaded");
    chk_cont_runs: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && running && !finiteMode && !stopCmd) |=> running) else $error("continuous stopped");
    chk_fifo_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
        level_reg <= (FIFO_AW+1)'(FIFO_DEPTH)) else $error("fifo level past depth");
    chk_pause_none: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (pauseTrig && hwPaced) |-> !startConv) else $error("conversion during pause");

    cov_overflow: cover property (@(posedge ref_clk) overwrite);
    cov_finite_done: cover property (@(posedge ref_clk) countHit);
    cov_late: cover property (@(posedge ref_clk) lateEvt);
    cov_burst: cover property (@(posedge ref_clk) dmaLast && dmaReady);
endmodule

// ---- tb/aiq_host_model.sv ----
`timescale 1ns/100ps
module aiq_host_model #(
    parameter int CONV_LAT = 3
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset_n,
    input  wire logic                       stall,
    input  wire logic                       convStart,
    output logic                            convDone,
    output logic [aiq_pkg::DATA_W-1:0]      convData,
    input  wire logic                       dmaValid,
    input  wire logic [aiq_pkg::DATA_W-1:0] dmaData,
    input  wire logic                       dmaLast,
    output logic                            dmaReady,
    output int                              wordCount,
    output int                              lastCount,
    output logic [aiq_pkg::DATA_W-1:0]      lastWord
);
    import aiq_pkg::*;
    logic [3:0]        delayReg;
    logic [DATA_W-1:0] seqReg;

    // converter: one answer per start, data bus toggles while idle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            delayReg <= 4'h0;
            seqReg   <= 16'hA000;
            convDone <= 1'b0;
            convData <= 16'h0000;
        end else begin
            convDone <= 1'b0;
            convData <= ~convData;
            if (convStart) begin
                delayReg <= 4'(CONV_LAT);
            end else if (delayReg != 4'h0) begin
                delayReg <= delayReg - 4'h1;
                if (delayReg == 4'h1) begin
                    convDone <= 1'b1;
                    convData <= seqReg;
                    seqReg   <= seqReg + 16'h0001;
                end
            end
        end
    end

    // host memory sink: stalls only when the bench asks
    assign dmaReady = !stall;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wordCount <= 0;
            lastCount <= 0;
            lastWord  <= '0;
        end else if (dmaValid && dmaReady) begin
            wordCount <= wordCount + 1;
            lastWord  <= dmaData;
            lastCount <= lastCount + int'(dmaLast);
        end
    end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import aiq_pkg::*;
    logic        ref_clk  = 1'b0;
    logic        reset_n  = 1'b0;
    logic [5:0]  regAddr  = 6'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead  = 1'b0;
    logic        extClk   = 1'b0;
    logic        stall    = 1'b0;
    logic        clkEn    = 1'b1;
    logic [1:0]  startT   = 2'h0; // bit0 digital, bit1 analog
    logic [1:0]  refT     = 2'h0;
    logic [1:0]  pauseT   = 2'h0;
    logic [31:0] regRdata;
    logic        irq, convStart, convDone, dmaValid, dmaLast, dmaReady, refSeen, running;
    logic [7:0]  convChannel;
    logic [2:0]  pgaRange;
    logic [1:0]  gndMode;
    logic [15:0] convData, dmaData, lastWord;
    logic [12:0] entryQ[$];
    int          stampQ[$];
    int          failCount = 0, nChecks = 0, cyc = 0, nConv = 0, wordCount, lastCount;

    always #2 ref_clk = ~ref_clk;

    aiq_sequencer #(.FIFO_DEPTH(16), .FIFO_AW(4), .BURST_LEN(4), .HAS_ANALOG(1'b1)) i_dut (
        .ref_clk, .reset_n, .clkEn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .irq, .extSampleClk(extClk), .digStartTrig(startT[0]), .anaStartTrig(startT[1]),
        .digRefTrig(refT[0]), .anaRefTrig(refT[1]), .digPauseTrig(pauseT[0]), .anaPauseTrig(pauseT[1]),
        .convStart, .convChannel, .pgaRange, .gndMode, .convDone, .convData, .dmaValid, .dmaData,
        .dmaLast, .dmaReady, .refSeen, .running);

    aiq_host_model #(.CONV_LAT(3)) i_host (
        .ref_clk, .reset_n, .stall, .convStart, .convDone, .convData, .dmaValid, .dmaData,
        .dmaLast, .dmaReady, .wordCount, .lastCount, .lastWord);

    always @(posedge ref_clk) begin
        cyc++;
        if (reset_n && convStart) begin
            nConv++;
            entryQ.push_back({gndMode, pgaRange, convChannel});
            stampQ.push_back(cyc);
        end
        if (cyc == 10000) begin
            failCount++;
            final_report();
        end
    end

    function automatic logic [31:0] se(input logic [7:0] c, input logic [2:0] r, input logic [1:0] g);
        return {19'h0, g, r, c};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(posedge ref_clk);
        `CHK(regRdata & m, e)
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        stall   <= 1'b0;
        clkEn   <= 1'b1;
        startT  <= 2'h0;
        refT    <= 2'h0;
        pauseT  <= 2'h0;
        tick(20);
        reset_n <= 1'b1;
        nConv = 0;
        entryQ.delete();
        stampQ.delete();
    endtask
    task automatic wait_run(input logic v, input int lim);
        for (int i = 0; i < lim && running !== v; i++) tick(1);
        `CHK(running, v)
    endtask
    task automatic start(input logic [31:0] ctrl, input logic [1:0] src);
        wr(REG_CTRL, ctrl);
        wr(REG_CMD, 32'h2);
        startT <= src;
        wait_run(1'b1, 50);
        startT <= 2'h0;
    endtask

    task automatic t_on_demand();
        do_reset();
        rd_chk(REG_COUNT, 32'hFFFFFFFF, 32'h1);
        rd_chk(REG_DIVIDER, 32'hFFFFFFFF, 32'hFA);
        rd_chk(REG_SCANLEN, 32'hFFFFFFFF, 32'h1);
        rd_chk(6'h3F, 32'hFFFFFFFF, 32'h0);
        wr(REG_SCAN0, se(8'h2A, 3'h5, GND_SENSED_SE));
        start(32'h0, 2'b01);
        tick(40);
        `CHK(nConv, 0)
        repeat (3) begin
            wr(REG_CMD, 32'h1);
            tick(10);
        end
        `CHK(nConv, 3)
        `CHK(entryQ[2], 13'(se(8'h2A, 3'h5, GND_SENSED_SE)))
        // with the clock enable low a command is not taken
        clkEn <= 1'b0;
        wr(REG_CMD, 32'h1);
        tick(10);
        clkEn <= 1'b1;
        tick(10);
        `CHK(nConv, 3)
        wr(REG_CMD, 32'h1);
        tick(10);
        `CHK(nConv, 4)
    endtask

    task automatic t_finite();
        logic [12:0] e0, e1;
        do_reset();
        e0 = 13'(se(8'h01, 3'h0, GND_TWO_WIRE));
        e1 = 13'(se(8'h09, 3'h6, GND_GROUNDED_SE));
        wr(REG_DIVIDER, 32'h7);
        wr(REG_COUNT, 32'h8);
        wr(REG_SCANLEN, 32'h2);
        wr(REG_SCAN0, {19'h0, e0});
        wr(REG_SCAN0 + 6'h01, {19'h0, e1});
        wr(REG_IRQ_MASK, 32'h1);
        start(32'h5, 2'b01); // buffered, finite
        wait_run(1'b0, 400);
        tick(40);
        `CHK(nConv, 8)
        for (int i = 1; i < 8; i++) begin
            `CHK(entryQ[i], i[0] ? e1 : e0)
            `CHK(stampQ[i] - stampQ[i-1], 8)
        end
        `CHK(wordCount, 8)
        `CHK(lastCount, 2)
        `CHK(lastWord, 16'hA007)
        `CHK(irq, 1'b1)
        rd_chk(REG_IRQ_STAT, 32'h1, 32'h1);
        wr(REG_IRQ_STAT, 32'h1);
        tick(1);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_pause();
        int n0;
        do_reset();
        wr(REG_DIVIDER, 32'h7);
        wr(REG_COUNT, 32'h2);
        start(32'h21, 2'b01); // buffered, continuous, pause enabled
        tick(100);
        `CHK(nConv > 4, 1'b1)
        `CHK(running, 1'b1)
        pauseT <= 2'b01;
        tick(10);
        n0 = nConv;
        tick(60);
        `CHK(nConv, n0)
        pauseT <= 2'h0;
        tick(40);
        `CHK(nConv > n0, 1'b1)
        wr(REG_CMD, 32'h4);
        wait_run(1'b0, 20);
    endtask

    task automatic t_overflow();
        do_reset();
        wr(REG_DIVIDER, 32'h3);
        wr(REG_IRQ_MASK, 32'h2);
        stall <= 1'b1;
        start(32'h1, 2'b01); // buffered, continuous, host stalled
        tick(200);
        `CHK(irq, 1'b1)
        wr(REG_CMD, 32'h4);
        rd_chk(REG_IRQ_STAT, 32'h2, 32'h2);
        wr(REG_IRQ_MASK, 32'h0);
        tick(1);
        `CHK(irq, 1'b0)
        wr(REG_IRQ_STAT, 32'h2);
        rd_chk(REG_IRQ_STAT, 32'h2, 32'h0);
        stall <= 1'b0;
        tick(60);
        `CHK(wordCount, 16)
        `CHK(lastWord, 16'(32'hA000 + nConv - 1))
    endtask

    task automatic t_late();
        do_reset();
        wr(REG_DIVIDER, 32'hF);
        wr(REG_IRQ_MASK, 32'h4);
        start(32'h2, 2'b01); // single point
        for (int k = 1; k < 4; k++) begin
            for (int i = 0; i < 40 && nConv < k; i++) tick(1);
            tick(6);
            rd_chk(REG_SPDATA, 32'hFFFF, 32'hA000 + 32'(k - 1));
        end
        `CHK(irq, 1'b0)
        tick(40);
        `CHK(irq, 1'b1)
        rd_chk(REG_IRQ_STAT, 32'h4, 32'h4);
    endtask

    task automatic t_external();
        do_reset();
        wr(REG_COUNT, 32'h4);
        wr(REG_TRIG, 32'h7); // all triggers from analog sources
        wr(REG_CTRL, 32'h1D);
        wr(REG_CMD, 32'h2);
        startT <= 2'b01;
        tick(20);
        `CHK(running, 1'b0)
        start(32'h1D, 2'b10); // finite, external clock and reference enabled
        tick(50);
        `CHK(nConv, 0)
        for (int k = 0; k < 4; k++) begin
            if (k == 2) refT <= 2'b10;
            extClk <= 1'b1;
            tick(10);
            extClk <= 1'b0;
            tick(10);
            if (k == 2) `CHK(refSeen, 1'b1)
        end
        `CHK(nConv, 4)
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        t_on_demand();
        t_finite();
        t_pause();
        t_overflow();
        t_late();
        t_external();
        final_report();
    end
endmodule
